// ---- design/acqcq_pkg.sv ----
// acquisition clock qualifier: shared constants, field layout and types
// assumes a single 100 MHz system clock; latch indices and pod-latch bit positions live here, qualifier pair fields in acqcq_top
package acqcq_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int PODS = 3;
  localparam int LATCHES = 6;
  localparam int SYNC_W = 29;

  // ----------------------------------------------------------------
  // latch indices (one selector strobe per latch)
  // ----------------------------------------------------------------
  localparam int L_FIRST = 0;
  localparam int L_SECOND = 1;
  localparam int L_THIRD = 2;
  localparam int L_POD_A = 3;
  localparam int L_POD_B = 4;
  localparam int L_POD_C = 5;

  // ----------------------------------------------------------------
  // bit positions inside the pod clock-enable latches
  // ----------------------------------------------------------------
  localparam int B_RISE_EN = 0;
  localparam int B_FALL_EN = 1;
  localparam int B_MASTER_SEL = 6;
  localparam int B_SEL7 = 7;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] LATCH_RST = 8'hff;
  localparam logic [SYNC_W-1:0] SYNC_RST = 29'h1000_003f;

  // ----------------------------------------------------------------
  // qualifier gate codes, written {odd, even}
  // ----------------------------------------------------------------
  localparam logic [1:0] CTL_ALWAYS = 2'h0;
  localparam logic [1:0] CTL_HIGH = 2'h1;
  localparam logic [1:0] CTL_LOW = 2'h2;
  localparam logic [1:0] CTL_NEVER = 2'h3;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 10;
  localparam int PULSE_NS = 20;
  localparam int PULSE_CYC_I = (PULSE_NS / CLK_NS < 1) ? 1 : PULSE_NS / CLK_NS;
  localparam logic [1:0] PULSE_CYC = 2'(PULSE_CYC_I);

  typedef enum logic [1:0] {
    ACQCQ_IDLE = 2'b00,
    ACQCQ_PULSE = 2'b01,
    ACQCQ_SET = 2'b11
  } acqcq_state_t;

endpackage

// ---- design/acqcq_pod_pulse.sv ----
// acquisition clock qualifier: pulse shaper for one pod clock
// assumes trig is a one-cycle qualified edge and preset a one-cycle set
`timescale 1ns/10ps
`default_nettype none
module acqcq_pod_pulse (
  input wire logic clk,
  input wire logic rst,
  input wire logic trig,
  input wire logic preset,
  output logic pulse
);

  acqcq_pkg::acqcq_state_t state_ff, nxt_state;
  logic [1:0] cnt_ff;
  logic [1:0] nxt_cnt;

  // ----------------------------------------------------------------
  // state machine: pulse, then a delayed set that returns to idle
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    case (state_ff)
      acqcq_pkg::ACQCQ_IDLE: begin
        if (trig) begin
          nxt_state = acqcq_pkg::ACQCQ_PULSE;
          nxt_cnt = acqcq_pkg::PULSE_CYC;
        end
      end
      acqcq_pkg::ACQCQ_PULSE: begin
        nxt_cnt = cnt_ff - 2'h1;
        if (cnt_ff == 2'h1) begin
          nxt_state = acqcq_pkg::ACQCQ_SET;
        end
      end
      acqcq_pkg::ACQCQ_SET: nxt_state = acqcq_pkg::ACQCQ_IDLE;
      default: nxt_state = acqcq_pkg::ACQCQ_IDLE;
    endcase
    if (preset) begin
      nxt_state = acqcq_pkg::ACQCQ_IDLE;
      nxt_cnt = 2'h0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= acqcq_pkg::ACQCQ_IDLE;
      cnt_ff <= 2'h0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
    end
  end

  assign pulse = (state_ff == acqcq_pkg::ACQCQ_PULSE);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_start;
    (state_ff == acqcq_pkg::ACQCQ_IDLE) && trig && !preset;
  endsequence
  sequence s_shape;
    pulse [*2] ##1 !pulse;
  endsequence

  // a set pulse landing inside the pulse may legally cut it short
  a_pulse_width: assert property (
    @(posedge clk) disable iff (rst)
    s_start ##1 !preset |-> s_shape
  ) else $error("pod pulse width wrong");

  a_preset_idle: assert property (
    @(posedge clk) disable iff (rst)
    preset |=> !pulse
  ) else $error("preset did not end pod pulse");

endmodule // acqcq_pod_pulse
`default_nettype wire

// ---- design/acqcq_qual_gate.sv ----
// acquisition clock qualifier: the three qualifier gates of one pod
// assumes synchronised qualifier levels and latched control pairs
`timescale 1ns/10ps
`default_nettype none
module acqcq_qual_gate (
  input wire logic [1:0] ctl_first,
  input wire logic [1:0] ctl_second,
  input wire logic [1:0] ctl_third,
  input wire logic q_first,
  input wire logic q_second,
  input wire logic q_third,
  output logic first_n,
  output logic second_n,
  output logic third_n
);

  // ----------------------------------------------------------------
  // pair decode
  // ----------------------------------------------------------------
  function automatic logic allow(input logic [1:0] ctl, input logic q);
    logic a;
    a = 1'b0;
    case (ctl)
      acqcq_pkg::CTL_ALWAYS: a = 1'b1;
      acqcq_pkg::CTL_HIGH: a = q;
      acqcq_pkg::CTL_LOW: a = ~q;
      default: a = 1'b0;
    endcase
    return a;
  endfunction

  logic third_ok;

  // ----------------------------------------------------------------
  // active-low outputs; third gate is folded into the other two
  // ----------------------------------------------------------------
  always_comb begin
    third_ok = allow(ctl_third, q_third);
    third_n = ~third_ok;
    first_n = ~(allow(ctl_first, q_first) & third_ok);
    second_n = ~(allow(ctl_second, q_second) & third_ok);
  end

endmodule // acqcq_qual_gate
`default_nettype wire

// ---- design/acqcq_top.sv ----
// acquisition clock qualifier: selector latches, qualifier gates,
// pod clock generation and master clock selection
// assumes every pin input is asynchronous to MCLK and slower than it
//
// What this block does
// - strobe latches data bus; latches drive enables
// - nine qualifier gates, three per pod
// - gate passes true, inverted or none; low
// - each gate steered by odd/even bit pair
// - 00 always, 01 high, 10 low, 11 never
// - third qualifier ANDed into first and second
// - exactly one master select passes its clock
// - fourth select chooses only the step clock
// - master clock fanned out as three copies
// - pod clocks from probes or companion clock
// - all three qualifiers gate the chosen probe clock edge
// - rising edge counts only with rise enable low
// - pulse ends about 20 ns, then preset
// - preset strobe low gives one set pulse
// - all external enables high stop probe clocks
// - companion edge clocks all pods if qualified
`timescale 1ns/10ps
`default_nettype none
module acqcq_top (
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire logic [7:0] DATA_BUS,
  input wire logic [5:0] SELECTOR_LATCH_STROBES_N,
  input wire logic [2:0] PROBE_CLOCKS,
  input wire logic [2:0] FIRST_QUALIFIER,
  input wire logic [2:0] SECOND_QUALIFIER,
  input wire logic [2:0] THIRD_QUALIFIER,
  input wire logic COMPANION_MODULE_CLOCK,
  input wire logic SINGLE_STEP_CLOCK,
  input wire logic CLOCK_PRESET_N,
  output logic [2:0] FIRST_QUAL_OUT_N,
  output logic [2:0] SECOND_QUAL_OUT_N,
  output logic [2:0] THIRD_QUAL_OUT_N,
  output logic [2:0] POD_CLOCKS,
  output logic [2:0] MASTER_CLOCK_COPIES
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [acqcq_pkg::SYNC_W-1:0] sync1_ff, sync2_ff;
  logic s_preset_n, s_step, s_comp;
  logic [2:0] s_q3, s_q2, s_q1, s_pclk;
  logic [7:0] s_data;
  logic [5:0] s_strb_n;

  // strobes and preset idle high so release from reset makes no edge
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      sync1_ff <= acqcq_pkg::SYNC_RST;
      sync2_ff <= acqcq_pkg::SYNC_RST;
    end else begin
      sync1_ff <= {CLOCK_PRESET_N, SINGLE_STEP_CLOCK, COMPANION_MODULE_CLOCK,
                   THIRD_QUALIFIER, SECOND_QUALIFIER, FIRST_QUALIFIER,
                   PROBE_CLOCKS, DATA_BUS, SELECTOR_LATCH_STROBES_N};
      sync2_ff <= sync1_ff;
    end
  end

  assign {s_preset_n, s_step, s_comp, s_q3, s_q2, s_q1, s_pclk, s_data,
          s_strb_n} = sync2_ff;

  // ----------------------------------------------------------------
  // edge history of the synchronised strobes and clocks
  // ----------------------------------------------------------------
  logic [5:0] prev_strb_ff;
  logic [2:0] prev_pclk_ff;
  logic prev_comp_ff;
  logic prev_preset_ff;

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      prev_strb_ff <= 6'h3f;
      prev_pclk_ff <= 3'h0;
      prev_comp_ff <= 1'b0;
      prev_preset_ff <= 1'b1;
    end else begin
      prev_strb_ff <= s_strb_n;
      prev_pclk_ff <= s_pclk;
      prev_comp_ff <= s_comp;
      prev_preset_ff <= s_preset_n;
    end
  end

  // ----------------------------------------------------------------
  // selector latches
  // ----------------------------------------------------------------
  // capture on the strobe's trailing (rising) edge, when the data bus
  // has had the whole strobe low time to settle
  logic [7:0] latch_ff [acqcq_pkg::LATCHES];
  logic [5:0] strb_rise;

  assign strb_rise = s_strb_n & ~prev_strb_ff;

  for (genvar l = 0; l < acqcq_pkg::LATCHES; l++) begin : g_latch
    always_ff @(posedge MCLK or posedge SYS_RST) begin
      if (SYS_RST) begin
        latch_ff[l] <= acqcq_pkg::LATCH_RST;
      end else if (strb_rise[l]) begin
        latch_ff[l] <= s_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // latch field decode
  // ----------------------------------------------------------------
  logic [5:0] first_qual_ctl_bits, second_qual_ctl_bits, third_qual_ctl_bits;
  logic [7:0] pod_ext_clock_enables [acqcq_pkg::PODS];
  logic [3:0] master_sel;
  logic companion_sel_low, companion_sel_high;

  always_comb begin
    first_qual_ctl_bits = latch_ff[acqcq_pkg::L_FIRST][5:0];
    second_qual_ctl_bits = latch_ff[acqcq_pkg::L_SECOND][5:0];
    third_qual_ctl_bits = latch_ff[acqcq_pkg::L_THIRD][5:0];
    pod_ext_clock_enables[0] = latch_ff[acqcq_pkg::L_POD_A];
    pod_ext_clock_enables[1] = latch_ff[acqcq_pkg::L_POD_B];
    pod_ext_clock_enables[2] = latch_ff[acqcq_pkg::L_POD_C];
    master_sel = {latch_ff[acqcq_pkg::L_POD_A][acqcq_pkg::B_SEL7],
                  latch_ff[acqcq_pkg::L_POD_C][acqcq_pkg::B_MASTER_SEL],
                  latch_ff[acqcq_pkg::L_POD_B][acqcq_pkg::B_MASTER_SEL],
                  latch_ff[acqcq_pkg::L_POD_A][acqcq_pkg::B_MASTER_SEL]};
    companion_sel_low = latch_ff[acqcq_pkg::L_POD_C][acqcq_pkg::B_SEL7];
    companion_sel_high = latch_ff[acqcq_pkg::L_POD_B][acqcq_pkg::B_SEL7];
  end

  // ----------------------------------------------------------------
  // preset: one set pulse per low-going preset strobe
  // ----------------------------------------------------------------
  logic set_ff;

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      set_ff <= 1'b0;
    end else begin
      set_ff <= prev_preset_ff & ~s_preset_n;
    end
  end

  // ----------------------------------------------------------------
  // companion clock path
  // ----------------------------------------------------------------
  logic comp_rise;
  logic comp_trig;

  assign comp_rise = s_comp & ~prev_comp_ff;
  // qualified by pod A's third-qualifier gate only
  assign comp_trig = comp_rise & ~companion_sel_low & companion_sel_high &
                     ~THIRD_QUAL_OUT_N[0];

  // ----------------------------------------------------------------
  // per pod: qualifier gates, edge select, pulse shaper
  // ----------------------------------------------------------------
  logic [2:0] gate_first_n, gate_second_n, gate_third_n;
  logic [2:0] edge_ok, trig_own, trig, pod_pulse;

  for (genvar p = 0; p < acqcq_pkg::PODS; p++) begin : g_pod
    acqcq_qual_gate u_gate (
      .ctl_first (first_qual_ctl_bits[2*p+1 -: 2]),
      .ctl_second (second_qual_ctl_bits[2*p+1 -: 2]),
      .ctl_third (third_qual_ctl_bits[2*p+1 -: 2]),
      .q_first (s_q1[p]),
      .q_second (s_q2[p]),
      .q_third (s_q3[p]),
      .first_n (gate_first_n[p]),
      .second_n (gate_second_n[p]),
      .third_n (gate_third_n[p])
    );

    // registered gate outputs line up with the one-cycle clock edge
    always_ff @(posedge MCLK or posedge SYS_RST) begin
      if (SYS_RST) begin
        FIRST_QUAL_OUT_N[p] <= 1'b1;
        SECOND_QUAL_OUT_N[p] <= 1'b1;
        THIRD_QUAL_OUT_N[p] <= 1'b1;
      end else begin
        FIRST_QUAL_OUT_N[p] <= gate_first_n[p];
        SECOND_QUAL_OUT_N[p] <= gate_second_n[p];
        THIRD_QUAL_OUT_N[p] <= gate_third_n[p];
      end
    end

    // enable bits are active low; both high leaves the probe clock dead
    always_comb begin
      edge_ok[p] = 1'b0;
      if (!pod_ext_clock_enables[p][acqcq_pkg::B_RISE_EN]) begin
        edge_ok[p] = s_pclk[p] & ~prev_pclk_ff[p];
      end else if (!pod_ext_clock_enables[p][acqcq_pkg::B_FALL_EN]) begin
        edge_ok[p] = ~s_pclk[p] & prev_pclk_ff[p];
      end
    end

    // this pod's qualifier gates decide on the probe clock edge
    assign trig_own[p] = edge_ok[p] & ~FIRST_QUAL_OUT_N[p] &
                         ~SECOND_QUAL_OUT_N[p] &
                         ~THIRD_QUAL_OUT_N[p];
    assign trig[p] = trig_own[p] | comp_trig;

    acqcq_pod_pulse u_pulse (
      .clk (MCLK),
      .rst (SYS_RST),
      .trig (trig[p]),
      .preset (set_ff),
      .pulse (pod_pulse[p])
    );
  end

  assign POD_CLOCKS = pod_pulse;

  // ----------------------------------------------------------------
  // master clock selector and fan-out
  // ----------------------------------------------------------------
  // a select word that is not one-hot passes nothing rather than a
  // merge of clocks, which would corrupt acquisition timing
  logic sel_onehot;
  logic nxt_master;
  logic [3:0] master_src;

  assign master_src = {s_step, pod_pulse};
  assign sel_onehot = (master_sel != 4'h0) &&
                      ((master_sel & (master_sel - 4'h1)) == 4'h0);
  assign nxt_master = sel_onehot & |(master_sel & master_src);

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      MASTER_CLOCK_COPIES <= 3'h0;
    end else begin
      MASTER_CLOCK_COPIES <= {3{nxt_master}};
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);

  a_latch_capture: assert property (
    strb_rise[acqcq_pkg::L_POD_A] |=>
    latch_ff[acqcq_pkg::L_POD_A] == $past(s_data)
  ) else $error("latch missed strobe");

  a_gate_never: assert property (
    first_qual_ctl_bits[1:0] == acqcq_pkg::CTL_NEVER |=> FIRST_QUAL_OUT_N[0]
  ) else $error("never code passed a qualifier");

  a_gate_high: assert property (
    (first_qual_ctl_bits[1:0] == acqcq_pkg::CTL_HIGH) && !s_q1[0] |=>
    FIRST_QUAL_OUT_N[0]
  ) else $error("high code passed a low qualifier");

  a_third_and: assert property (
    gate_third_n[1] |=> FIRST_QUAL_OUT_N[1] && SECOND_QUAL_OUT_N[1]
  ) else $error("third qualifier not ANDed in");

  a_master_mask: assert property (
    !sel_onehot |=> MASTER_CLOCK_COPIES == 3'h0
  ) else $error("master clock passed without one select");

  a_step_path: assert property (
    master_sel == 4'h8 |=> MASTER_CLOCK_COPIES[0] == $past(s_step)
  ) else $error("step clock not selected");

  a_copies_same: assert property (
    MASTER_CLOCK_COPIES[0] == MASTER_CLOCK_COPIES[1] &&
    MASTER_CLOCK_COPIES[1] == MASTER_CLOCK_COPIES[2]
  ) else $error("master copies differ");

  a_qual_block: assert property (
    trig_own[0] |-> !FIRST_QUAL_OUT_N[0] && $rose(s_pclk[0]) ||
                    !FIRST_QUAL_OUT_N[0] && $fell(s_pclk[0])
  ) else $error("pod edge taken without qualifier");

  a_ext_disable: assert property (
    pod_ext_clock_enables[2][1:0] == 2'h3 |-> !edge_ok[2]
  ) else $error("disabled probe clock made an edge");

  // pods idle now and one cycle ago: no shaper is mid-pulse or in set
  logic [2:0] prev_pods_ff;
  logic pods_idle;

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      prev_pods_ff <= 3'h0;
    end else begin
      prev_pods_ff <= pod_pulse;
    end
  end

  assign pods_idle = (pod_pulse == 3'h0) && (prev_pods_ff == 3'h0);

  a_companion: assert property (
    comp_trig && !set_ff && pods_idle |=>
    POD_CLOCKS == 3'h7
  ) else $error("companion edge missed a pod");

  a_preset_once: assert property (
    set_ff |=> !set_ff
  ) else $error("preset gave more than one set pulse");

endmodule // acqcq_top
`default_nettype wire

// ---- tb/acq_clock_qualifier_bench.sv ----
// acquisition clock qualifier bench: latch programming, gates, pod clocks
// assumes acqcq_top and acqcq_probe_model; inputs change by nba on MCLK
`timescale 1ns/10ps
`default_nettype none
module acq_clock_qualifier_bench;
  logic MCLK, SYS_RST, STEP, PRESET_N, run, comp_run;
  logic [7:0] DATA_BUS;
  logic [5:0] strobes_n;
  logic [2:0] lv_first, lv_second, lv_third, pclk, fq, sq, tq;
  logic [2:0] first_n, second_n, third_n, pods, mst, pod_q;
  logic comp_clk, mst_q;
  int failures, tests_run, cycles, mst_rise, mst_split;
  int pod_rise [3];
  int pod_high [3];

  acqcq_top u_dut (.MCLK(MCLK), .SYS_RST(SYS_RST), .DATA_BUS(DATA_BUS),
    .SELECTOR_LATCH_STROBES_N(strobes_n), .PROBE_CLOCKS(pclk),
    .FIRST_QUALIFIER(fq), .SECOND_QUALIFIER(sq), .THIRD_QUALIFIER(tq),
    .COMPANION_MODULE_CLOCK(comp_clk), .SINGLE_STEP_CLOCK(STEP),
    .CLOCK_PRESET_N(PRESET_N), .FIRST_QUAL_OUT_N(first_n),
    .SECOND_QUAL_OUT_N(second_n), .THIRD_QUAL_OUT_N(third_n),
    .POD_CLOCKS(pods), .MASTER_CLOCK_COPIES(mst));

  acqcq_probe_model u_probe (.run(run), .comp_run(comp_run),
    .lv_first(lv_first), .lv_second(lv_second), .lv_third(lv_third),
    .probe_clocks(pclk), .first_q(fq), .second_q(sq), .third_q(tq),
    .companion_clock(comp_clk));

  initial begin
    MCLK = 1'b0;
    forever #5 MCLK = ~MCLK;
  end

  // ----------------------------------------------------------------
  // edge counters and watchdog
  // ----------------------------------------------------------------
  always @(posedge MCLK) begin
    pod_q <= pods;
    mst_q <= mst[0];
    for (int k = 0; k < 3; k++) begin
      if (pods[k] === 1'b1 && pod_q[k] === 1'b0) pod_rise[k]++;
      if (pods[k] === 1'b1) pod_high[k]++;
    end
    if (mst[0] === 1'b1 && mst_q === 1'b0) mst_rise++;
    if (mst !== {3{mst[0]}}) mst_split++;
    cycles++;
    // a hang here would otherwise stall the run forever
    if (cycles == 6000) begin
      failures++;
      test_done();
    end
  end

  task automatic test_done();
    if (failures == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [7:0] exp,
                       input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  function automatic logic allow(input logic [1:0] c, input logic q);
    case (c)
      acqcq_pkg::CTL_ALWAYS: return 1'b1;
      acqcq_pkg::CTL_HIGH: return q;
      acqcq_pkg::CTL_LOW: return !q;
      default: return 1'b0;
    endcase
  endfunction

  // strobe low 3 cycles, high again, data held until the latch has it
  task automatic load(input int idx, input logic [7:0] d);
    @(posedge MCLK);
    DATA_BUS <= d;
    strobes_n[idx] <= 1'b0;
    repeat (3) @(posedge MCLK);
    strobes_n[idx] <= 1'b1;
    repeat (6) @(posedge MCLK);
  endtask

  task automatic clear_counts();
    @(negedge MCLK);
    pod_rise = '{0, 0, 0};
    pod_high = '{0, 0, 0};
    mst_rise = 0;
    mst_split = 0;
  endtask

  // four link clock periods, then time for the last pulse to finish
  task automatic frame(input logic comp);
    clear_counts();
    @(posedge MCLK);
    run <= 1'b1;
    comp_run <= comp;
    repeat (31) @(posedge MCLK);
    run <= 1'b0;
    repeat (20) @(posedge MCLK);
  endtask

  task automatic check_pods(input int a, input int b, input int c);
    check("pod_a_count", 8'(a), 8'(pod_rise[0]));
    check("pod_b_count", 8'(b), 8'(pod_rise[1]));
    check("pod_c_count", 8'(c), 8'(pod_rise[2]));
    check("pod_a_width", 8'(2 * a), 8'(pod_high[0]));
    check("copies_split", 8'h00, 8'(mst_split));
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic test_reset_state();
    check("first_rst", 8'h07, {5'h00, first_n});
    check("third_rst", 8'h07, {5'h00, third_n});
    check("pods_rst", 8'h00, {5'h00, pods});
    check("master_rst", 8'h00, {5'h00, mst});
  endtask

  task automatic test_gate_codes();
    logic [1:0] c;
    logic [2:0] ef, es;
    lv_first <= 3'h2;
    lv_second <= 3'h5;
    load(acqcq_pkg::L_THIRD, 8'h00);
    for (int i = 0; i < 4; i++) begin
      c = 2'(i);
      load(acqcq_pkg::L_FIRST, {2'h0, c, c, c});
      load(acqcq_pkg::L_SECOND, {2'h0, c, c, c});
      for (int k = 0; k < 3; k++) begin
        ef[k] = !allow(c, lv_first[k]);
        es[k] = !allow(c, lv_second[k]);
      end
      check("first_out", {5'h00, ef}, {5'h00, first_n});
      check("second_out", {5'h00, es}, {5'h00, second_n});
      check("third_out", 8'h00, {5'h00, third_n});
    end
    // third follows the qualifier level and holds first off where false
    lv_third <= 3'h1;
    load(acqcq_pkg::L_FIRST, 8'h00);
    load(acqcq_pkg::L_THIRD, 8'h15);
    check("third_gate", 8'h06, {5'h00, third_n});
    check("first_anded", 8'h06, {5'h00, first_n});
  endtask

  task automatic test_probe_edges();
    lv_third <= 3'h7;
    load(acqcq_pkg::L_SECOND, 8'h00);
    load(acqcq_pkg::L_POD_A, 8'h40);
    load(acqcq_pkg::L_POD_B, 8'h03);
    load(acqcq_pkg::L_POD_C, 8'h01);
    frame(1'b0);
    check_pods(4, 0, 4);
    check("master_pod_a", 8'h04, 8'(mst_rise));
    // pod A third qualifier wanted high while the pin sits low
    lv_third <= 3'h6;
    load(acqcq_pkg::L_THIRD, 8'h01);
    frame(1'b0);
    check_pods(0, 0, 4);
  endtask

  task automatic test_companion();
    lv_third <= 3'h7;
    load(acqcq_pkg::L_THIRD, 8'h00);
    load(acqcq_pkg::L_POD_A, 8'h7f);
    load(acqcq_pkg::L_POD_B, 8'hbf);
    load(acqcq_pkg::L_POD_C, 8'h3f);
    frame(1'b0);
    check_pods(0, 0, 0);
    frame(1'b1);
    check_pods(4, 4, 4);
    load(acqcq_pkg::L_THIRD, 8'h03);
    frame(1'b1);
    check_pods(0, 0, 0);
  endtask

  task automatic step_pulses();
    clear_counts();
    for (int i = 0; i < 3; i++) begin
      @(posedge MCLK);
      STEP <= 1'b1;
      repeat (4) @(posedge MCLK);
      STEP <= 1'b0;
      repeat (4) @(posedge MCLK);
    end
    repeat (4) @(posedge MCLK);
  endtask

  task automatic test_step_and_preset();
    load(acqcq_pkg::L_POD_B, 8'h3f);
    load(acqcq_pkg::L_POD_A, 8'hbf);
    step_pulses();
    check("master_step", 8'h03, 8'(mst_rise));
    check("copies_split", 8'h00, 8'(mst_split));
    // two selects raised together must mask the master clock
    load(acqcq_pkg::L_POD_A, 8'hff);
    step_pulses();
    check("master_two_sel", 8'h00, 8'(mst_rise));
    // one probe edge with a preset right behind it: the set cuts the
    // pulse to one cycle, and the shaper takes the next frame cleanly
    load(acqcq_pkg::L_THIRD, 8'h00);
    load(acqcq_pkg::L_POD_A, 8'h40);
    clear_counts();
    @(posedge MCLK);
    run <= 1'b1;
    comp_run <= 1'b0;
    PRESET_N <= 1'b0;
    repeat (4) @(posedge MCLK);
    run <= 1'b0;
    PRESET_N <= 1'b1;
    repeat (20) @(posedge MCLK);
    check("pods_preset", 8'h01, 8'(pod_high[0]));
    check("pod_a_cut_rise", 8'h01, 8'(pod_rise[0]));
    frame(1'b0);
    check("pod_a_after_set", 8'h04, 8'(pod_rise[0]));
  endtask

  initial begin
    SYS_RST = 1'b1;
    STEP = 1'b0;
    PRESET_N = 1'b1;
    run = 1'b0;
    comp_run = 1'b0;
    DATA_BUS = 8'h00;
    strobes_n = 6'h3f;
    lv_first = 3'h0;
    lv_second = 3'h0;
    lv_third = 3'h0;
    repeat (8) @(posedge MCLK);
    SYS_RST <= 1'b0;
    repeat (3) @(posedge MCLK);
    test_reset_state();
    test_gate_codes();
    test_probe_edges();
    test_companion();
    test_step_and_preset();
    test_done();
  end
endmodule // acq_clock_qualifier_bench
`default_nettype wire

// ---- tb/acqcq_probe_model.sv ----
// acquisition clock qualifier bench: behavioural probe pods and companion
// assumes run and comp_run come from the bench; clocks idle low outside frames
`timescale 1ns/10ps
`default_nettype none
module acqcq_probe_model (
  input wire logic run,
  input wire logic comp_run,
  input wire logic [2:0] lv_first,
  input wire logic [2:0] lv_second,
  input wire logic [2:0] lv_third,
  output logic [2:0] probe_clocks,
  output logic [2:0] first_q,
  output logic [2:0] second_q,
  output logic [2:0] third_q,
  output logic companion_clock
);
  // qualifiers are plain levels held by the pod until the bench moves them
  assign first_q = lv_first;
  assign second_q = lv_second;
  assign third_q = lv_third;

  // ----------------------------------------------------------------
  // link clocks: 80 ns period, only inside frames
  // ----------------------------------------------------------------
  // the 3 ns lead keeps probe edges off the system clock edges
  initial begin
    probe_clocks = 3'h0;
    companion_clock = 1'b0;
    forever begin
      wait (run);
      #3;
      probe_clocks = 3'h7;
      companion_clock = comp_run;
      #40;
      probe_clocks = 3'h0;
      companion_clock = 1'b0;
      #37;
    end
  end
endmodule // acqcq_probe_model
`default_nettype wire
